// file: pledc_top.sv
// Indicator LED source selection, event stretching and test blinking.
`timescale 1ns/1ps
module pledc_top
    import pledc_pkg::*;
#(
    parameter logic [PLEDC_CNT_W-1:0] HOLD_30_CYC = PLEDC_CNT_W'(PLEDC_HOLD_30_CYC),
    parameter logic [PLEDC_CNT_W-1:0] HOLD_60_CYC = PLEDC_CNT_W'(PLEDC_HOLD_60_CYC),
    parameter logic [PLEDC_CNT_W-1:0] HOLD_100_CYC = PLEDC_CNT_W'(PLEDC_HOLD_100_CYC),
    parameter logic [PLEDC_CNT_W-1:0] FAST_HALF_CYC = PLEDC_CNT_W'(PLEDC_FAST_HALF_CYC),
    parameter logic [PLEDC_CNT_W-1:0] SLOW_HALF_CYC = PLEDC_CNT_W'(PLEDC_SLOW_HALF_CYC)
)
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [4:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire logic link_up_in,
    input wire logic speed_100_in,
    input wire logic full_duplex_in,
    input wire logic tx_event_in,
    input wire logic rx_event_in,
    input wire logic col_event_in,
    output logic led_a_out,
    output logic led_b_out,
    output logic led_c_out
);

    // Configuration register and its read data latch.
    logic [15:0] cfg_q;
    logic [15:0] rdata_q;
    // Field views of the configuration register.
    wire [3:0] indicator_a_select = cfg_q[PLEDC_A_LSB +: 4];
    wire [3:0] indicator_b_select = cfg_q[PLEDC_B_LSB +: 4];
    wire [3:0] indicator_c_select = cfg_q[PLEDC_C_LSB +: 4];
    wire [1:0] event_hold_time_select = cfg_q[PLEDC_HOLD_LSB +: 2];
    wire stretch_en = cfg_q[PLEDC_STRETCH_BIT];
    // Address match for the one register that lives here.
    wire cfg_hit = (reg_addr_in == PLEDC_CFG_ADDR);

    // Writes take effect at once; reserved bit 0 is never stored.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            cfg_q <= PLEDC_CFG_RESET;
        end
        else if (reg_wr_in && cfg_hit)
        begin
            cfg_q <= reg_wdata_in & PLEDC_CFG_MASK;
        end
    end

    // Read data appears one cycle after the read strobe; other addresses read zero.
    wire [15:0] rdata_d = cfg_hit ? cfg_q : 16'h0000;
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rdata_q <= 16'h0000;
        end
        else if (reg_rd_in)
        begin
            rdata_q <= rdata_d;
        end
    end
    assign reg_rdata_out = rdata_q;

    // Hold length chosen by the field; the reserved code falls back to 30 ms,
    // since some finite, visible hold is safer than freezing the stretchers.
    wire [PLEDC_CNT_W-1:0] hold_cycles =
        (event_hold_time_select == PLEDC_HOLD_60) ? HOLD_60_CYC :
        (event_hold_time_select == PLEDC_HOLD_100) ? HOLD_100_CYC : HOLD_30_CYC;

    // Raw events in stretcher order; activity is either direction.
    wire [PLEDC_EV_N-1:0] raw_ev = {tx_event_in | rx_event_in, col_event_in,
                                    rx_event_in, tx_event_in};
    // Stretched view of each event, always computed.
    wire [PLEDC_EV_N-1:0] str_ev;
    // Per-stretcher down counters.
    logic [PLEDC_CNT_W-1:0] hold_cnt_q [PLEDC_EV_N];

    // One stretcher per event kind. An event reloads the counter so the
    // indication stays lit for the hold time after the last event.
    genvar gi;
    generate
        for (gi = 0; gi < PLEDC_EV_N; gi++)
        begin : g_str
            wire [PLEDC_CNT_W-1:0] cnt_d = raw_ev[gi] ? hold_cycles - 1'b1 :
                (hold_cnt_q[gi] != '0) ? hold_cnt_q[gi] - 1'b1 : hold_cnt_q[gi];
            always_ff @(posedge clk_in or negedge rst_n_in)
            begin
                if (!rst_n_in)
                begin
                    hold_cnt_q[gi] <= '0;
                end
                else
                begin
                    hold_cnt_q[gi] <= cnt_d;
                end
            end
            assign str_ev[gi] = raw_ev[gi] | (hold_cnt_q[gi] != '0);
        end
    endgenerate

    // Plain event modes follow the global enable; combined modes ignore it.
    wire [PLEDC_EV_N-1:0] shown_ev = stretch_en ? str_ev : raw_ev;

    // Free-running blink generators for the two test rates.
    logic [PLEDC_CNT_W-1:0] fast_cnt_q;
    logic [PLEDC_CNT_W-1:0] slow_cnt_q;
    logic fast_blink_q;
    logic slow_blink_q;
    wire fast_wrap = (fast_cnt_q == '0);
    wire slow_wrap = (slow_cnt_q == '0);

    // Each generator toggles once per half period.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            fast_cnt_q <= '0;
            slow_cnt_q <= '0;
            fast_blink_q <= 1'b0;
            slow_blink_q <= 1'b0;
        end
        else
        begin
            fast_cnt_q <= fast_wrap ? FAST_HALF_CYC - 1'b1 : fast_cnt_q - 1'b1;
            slow_cnt_q <= slow_wrap ? SLOW_HALF_CYC - 1'b1 : slow_cnt_q - 1'b1;
            fast_blink_q <= fast_wrap ? ~fast_blink_q : fast_blink_q;
            slow_blink_q <= slow_wrap ? ~slow_blink_q : slow_blink_q;
        end
    end

    // Maps one selection code onto an indicator level. Combined modes show
    // the primary level inverted while the secondary event is stretched.
    // Every level the function reads comes in as an argument, because a
    // continuous assignment only wakes up when its own operands change.
    function automatic logic led_level(input logic [3:0] sel,
                                       input logic [PLEDC_EV_N-1:0] ev,
                                       input logic [PLEDC_EV_N-1:0] forced,
                                       input logic spd,
                                       input logic lnk,
                                       input logic dpx,
                                       input logic fst,
                                       input logic slw);
        logic lvl;
        lvl = 1'b0;
        case (sel)
            PLEDC_SEL_SPEED: lvl = spd;
            PLEDC_SEL_TX: lvl = ev[PLEDC_EV_TX];
            PLEDC_SEL_RX: lvl = ev[PLEDC_EV_RX];
            PLEDC_SEL_COL: lvl = ev[PLEDC_EV_COL];
            PLEDC_SEL_LINK: lvl = lnk;
            PLEDC_SEL_DUPLEX: lvl = dpx;
            PLEDC_SEL_ACT: lvl = ev[PLEDC_EV_ACT];
            PLEDC_SEL_ON: lvl = 1'b1;
            PLEDC_SEL_OFF: lvl = 1'b0;
            PLEDC_SEL_FAST: lvl = fst;
            PLEDC_SEL_SLOW: lvl = slw;
            PLEDC_SEL_LINK_RX: lvl = lnk ^ forced[PLEDC_EV_RX];
            PLEDC_SEL_LINK_ACT: lvl = lnk ^ forced[PLEDC_EV_ACT];
            PLEDC_SEL_DUP_COL: lvl = dpx ^ forced[PLEDC_EV_COL];
            default: lvl = 1'b0; // Unused codes keep the indicator dark.
        endcase
        return lvl;
    endfunction : led_level

    // Next levels of the three indicators.
    wire led_a_d = led_level(indicator_a_select, shown_ev, str_ev, speed_100_in,
                             link_up_in, full_duplex_in, fast_blink_q, slow_blink_q);
    wire led_b_d = led_level(indicator_b_select, shown_ev, str_ev, speed_100_in,
                             link_up_in, full_duplex_in, fast_blink_q, slow_blink_q);
    wire led_c_d = led_level(indicator_c_select, shown_ev, str_ev, speed_100_in,
                             link_up_in, full_duplex_in, fast_blink_q, slow_blink_q);
    logic led_a_q;
    logic led_b_q;
    logic led_c_q;

    // Output flops keep the pins glitch free; they cost one cycle of latency.
    always_ff @(posedge clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            led_a_q <= 1'b0;
            led_b_q <= 1'b0;
            led_c_q <= 1'b0;
        end
        else
        begin
            led_a_q <= led_a_d;
            led_b_q <= led_b_d;
            led_c_q <= led_c_d;
        end
    end
    assign led_a_out = led_a_q;
    assign led_b_out = led_b_q;
    assign led_c_out = led_c_q;

    // Speed mode follows the speed input with one cycle of delay.
    AST_SPEED_A: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_a_select == PLEDC_SEL_SPEED) |=> (led_a_q == $past(speed_100_in)))
        else $error("Speed mode does not follow speed input.");

    // Link mode on indicator B follows the link input.
    AST_LINK_B: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_b_select == PLEDC_SEL_LINK) |=> (led_b_q == $past(link_up_in)))
        else $error("Link mode does not follow link input.");

    // A receive event keeps the stretched receive view lit for two more cycles.
    AST_RX_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (rx_event_in && hold_cycles > 24'h000003) |=> str_ev[PLEDC_EV_RX] [*2])
        else $error("Receive event not stretched.");

    // An event loads its counter with the selected hold minus one.
    AST_HOLD_LOAD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        tx_event_in |=> (hold_cnt_q[PLEDC_EV_TX] == $past(hold_cycles) - 1'b1))
        else $error("Hold counter loaded with wrong length.");

    // With stretching off, the transmit mode shows the raw event only.
    AST_NO_STRETCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!stretch_en && indicator_c_select == PLEDC_SEL_TX) |=> (led_c_q == $past(tx_event_in)))
        else $error("Transmit mode stretched while stretching is off.");

    // Combined link and receive stretches even with the global enable off.
    AST_COMBINED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!stretch_en && indicator_a_select == PLEDC_SEL_LINK_RX && rx_event_in)
        |=> (led_a_q == !$past(link_up_in)))
        else $error("Combined mode not driven by stretched receive.");

    // Duplex and collision mode inverts the duplex level during a collision.
    AST_DUP_COL: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_b_select == PLEDC_SEL_DUP_COL && col_event_in)
        |=> (led_b_q == !$past(full_duplex_in)))
        else $error("Collision does not toggle duplex indicator.");

    // Forced on mode lights the indicator.
    AST_FORCE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_c_select == PLEDC_SEL_ON) |=> led_c_q)
        else $error("Forced on indicator is dark.");

    // Unused codes keep the indicator dark.
    AST_UNUSED: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_a_select == 4'h6 || indicator_a_select == 4'hF) |=> !led_a_q)
        else $error("Unused code lights the indicator.");

    // The fast blink toggles exactly when its counter wraps.
    AST_BLINK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        fast_wrap |=> (fast_blink_q != $past(fast_blink_q)))
        else $error("Fast blink did not toggle at wrap.");

    // Activity mode responds to either direction.
    AST_ACT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_b_select == PLEDC_SEL_ACT && (tx_event_in || rx_event_in)) |=> led_b_q)
        else $error("Activity mode missed an event.");

    // Link and activity mode inverts link during activity.
    AST_LINK_ACT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_c_select == PLEDC_SEL_LINK_ACT && tx_event_in)
        |=> (led_c_q == !$past(link_up_in)))
        else $error("Activity does not toggle link indicator.");

    // Link and receive on indicator B during receive.
    AST_LINK_RX: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_b_select == PLEDC_SEL_LINK_RX && rx_event_in)
        |=> (led_b_q == !$past(link_up_in)))
        else $error("Receive does not toggle link indicator.");

    // A read returns the stored configuration one cycle later.
    AST_READ: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_rd_in && cfg_hit && !reg_wr_in) |=> (reg_rdata_out == $past(cfg_q)))
        else $error("Configuration read back wrong.");

    // Forced off mode keeps the indicator dark.
    AST_FORCE_OFF: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_c_select == PLEDC_SEL_OFF) |=> !led_c_q)
        else $error("Forced off indicator is lit.");

    // The slow blink toggles exactly when its counter wraps.
    AST_SLOW_BLINK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        slow_wrap |=> (slow_blink_q != $past(slow_blink_q)))
        else $error("Slow blink did not toggle at wrap.");

    // A write to the register lands in the next cycle, without bit 0.
    AST_WRITE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (reg_wr_in && cfg_hit) |=> (cfg_q == ($past(reg_wdata_in) & PLEDC_CFG_MASK)))
        else $error("Configuration write did not land.");

    // The stretched view ends once its counter runs out with no new event.
    AST_HOLD_EXPIRE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (!tx_event_in && hold_cnt_q[PLEDC_EV_TX] == 24'h000001) ##1 !tx_event_in
        |-> !str_ev[PLEDC_EV_TX])
        else $error("Stretched transmit view outlasts its hold.");

    // Duplex mode on indicator C follows the duplex input.
    AST_DUPLEX_C: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (indicator_c_select == PLEDC_SEL_DUPLEX) |=> (led_c_q == $past(full_duplex_in)))
        else $error("Duplex mode does not follow duplex input.");

    // With stretching on, a transmit event lights the transmit indicator.
    AST_TX_STRETCH: assert property (@(posedge clk_in) disable iff (!rst_n_in)
        (stretch_en && indicator_a_select == PLEDC_SEL_TX && tx_event_in) |=> led_a_q)
        else $error("Transmit event not shown.");

endmodule : pledc_top

// file: pledc_pkg.sv
// Constants, field layout and timing counts for the indicator LED control block.
// Overview of operation
// - Code 0000 shows link speed, unstretched.
// - Codes 0001-0011 show stretched transmit, receive, collision.
// - Code 0100 shows link, 0101 duplex, continuous.
// - Code 0111 shows stretched receive or transmit activity.
// - Codes 1000-1011 force on, off, fast, slow.
// - Code 1100: on with link, toggles on receive.
// - Code 1101: on with link, toggles on activity.
// - Code 1110: on when full duplex, toggles on collision.
// - Combined modes stretch regardless of global enable.
// - Hold field selects 30, 60, 100 ms.
// - Reset selects speed, link, receive, hold 00.
// - Codes 0110 and 1111 unused, LED off.
// - Global stretch enable bit, reset to one.
package pledc_pkg;

    // Management address of the configuration register.
    localparam logic [4:0] PLEDC_CFG_ADDR = 5'h14;
    // Reset value: A speed, B link, C receive, hold 00, stretch on.
    localparam logic [15:0] PLEDC_CFG_RESET = 16'h0422;
    // Field positions inside the configuration register.
    localparam int PLEDC_A_LSB = 12;
    localparam int PLEDC_B_LSB = 8;
    localparam int PLEDC_C_LSB = 4;
    localparam int PLEDC_HOLD_LSB = 2;
    localparam int PLEDC_STRETCH_BIT = 1;
    // Bit 0 has no function and always reads as zero.
    localparam logic [15:0] PLEDC_CFG_MASK = 16'hFFFE;

    // Source selection codes of one indicator.
    localparam logic [3:0] PLEDC_SEL_SPEED = 4'h0;
    localparam logic [3:0] PLEDC_SEL_TX = 4'h1;
    localparam logic [3:0] PLEDC_SEL_RX = 4'h2;
    localparam logic [3:0] PLEDC_SEL_COL = 4'h3;
    localparam logic [3:0] PLEDC_SEL_LINK = 4'h4;
    localparam logic [3:0] PLEDC_SEL_DUPLEX = 4'h5;
    localparam logic [3:0] PLEDC_SEL_ACT = 4'h7;
    localparam logic [3:0] PLEDC_SEL_ON = 4'h8;
    localparam logic [3:0] PLEDC_SEL_OFF = 4'h9;
    localparam logic [3:0] PLEDC_SEL_FAST = 4'hA;
    localparam logic [3:0] PLEDC_SEL_SLOW = 4'hB;
    localparam logic [3:0] PLEDC_SEL_LINK_RX = 4'hC;
    localparam logic [3:0] PLEDC_SEL_LINK_ACT = 4'hD;
    localparam logic [3:0] PLEDC_SEL_DUP_COL = 4'hE;

    // Hold time field codes.
    localparam logic [1:0] PLEDC_HOLD_30 = 2'h0;
    localparam logic [1:0] PLEDC_HOLD_60 = 2'h1;
    localparam logic [1:0] PLEDC_HOLD_100 = 2'h2;

    // Clock rate and the times in milliseconds.
    localparam int PLEDC_CLK_KHZ = 40000;
    localparam int PLEDC_HOLD_30_MS = 30;
    localparam int PLEDC_HOLD_60_MS = 60;
    localparam int PLEDC_HOLD_100_MS = 100;
    localparam int PLEDC_FAST_HALF_MS = 50;
    localparam int PLEDC_SLOW_HALF_MS = 250;
    // Width of every time counter; holds up to 16.7 million cycles.
    localparam int PLEDC_CNT_W = 24;
    // Derived cycle counts; all divide exactly at 40 MHz.
    localparam int PLEDC_HOLD_30_CYC = PLEDC_HOLD_30_MS * PLEDC_CLK_KHZ;
    localparam int PLEDC_HOLD_60_CYC = PLEDC_HOLD_60_MS * PLEDC_CLK_KHZ;
    localparam int PLEDC_HOLD_100_CYC = PLEDC_HOLD_100_MS * PLEDC_CLK_KHZ;
    localparam int PLEDC_FAST_HALF_CYC = PLEDC_FAST_HALF_MS * PLEDC_CLK_KHZ;
    localparam int PLEDC_SLOW_HALF_CYC = PLEDC_SLOW_HALF_MS * PLEDC_CLK_KHZ;

    // Index of each event stretcher.
    localparam int PLEDC_EV_TX = 0;
    localparam int PLEDC_EV_RX = 1;
    localparam int PLEDC_EV_COL = 2;
    localparam int PLEDC_EV_ACT = 3;
    localparam int PLEDC_EV_N = 4;

endpackage : pledc_pkg

// file: pledc_led_model.sv
// Partner model of the three external indicator LEDs, integrating lit time per lamp.
`timescale 1ns/1ps
module pledc_led_model
(
    input wire logic clk_in,
    input wire logic clear_in,
    input wire logic led_a_in,
    input wire logic led_b_in,
    input wire logic led_c_in,
    output logic [15:0] lit_a_out,
    output logic [15:0] lit_b_out,
    output logic [15:0] lit_c_out
);
    // A lamp only shows how long it was lit, so each one keeps a lit-cycle count.
    always_ff @(posedge clk_in)
    begin
        if (clear_in)
        begin
            lit_a_out <= 16'h0000;
            lit_b_out <= 16'h0000;
            lit_c_out <= 16'h0000;
        end
        else
        begin
            lit_a_out <= lit_a_out + 16'(led_a_in);
            lit_b_out <= lit_b_out + 16'(led_b_in);
            lit_c_out <= lit_c_out + 16'(led_c_in);
        end
    end
endmodule : pledc_led_model

// file: pledc_top_tb_top.sv
// Self-checking testbench of the indicator LED control block.
`timescale 1ns/1ps
module pledc_top_tb_top;
    import pledc_pkg::*;
    // Short counts keep the run brief; every timing expectation derives from these.
    localparam logic [23:0] H30 = 24'h10, H60 = 24'h20, H100 = 24'h40, FH = 24'h8, SH = 24'h20;
    logic clk_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0, clear = 1'b0;
    logic link = 1'b1, spd = 1'b1, dup = 1'b1, tx = 1'b0, rx = 1'b0, col = 1'b0;
    logic [4:0] reg_addr_in = 5'h00;
    logic [15:0] reg_wdata_in = 16'h0000, reg_rdata_out, lit_a, lit_b, lit_c, rd_val;
    logic led_a_out, led_b_out, led_c_out;
    logic [2:0] exp3;
    // The three indicator levels as one word for the checker.
    wire [15:0] leds_seen = {13'h0000, led_a_out, led_b_out, led_c_out};
    int n_mismatch = 0, total_checks = 0, cycles = 0, seed = 32'hCE28, n, i, k;
    logic [3:0] cont_codes [7] = '{4'h0, 4'h4, 4'h5, 4'h8, 4'h9, 4'h6, 4'hF};
    logic [3:0] ev_codes [7] = '{4'h1, 4'h2, 4'h3, 4'h7, 4'hC, 4'hD, 4'hE};
    pledc_top #(.HOLD_30_CYC(H30), .HOLD_60_CYC(H60), .HOLD_100_CYC(H100),
        .FAST_HALF_CYC(FH), .SLOW_HALF_CYC(SH)) pledc_top_i (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .reg_addr_in(reg_addr_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
        .link_up_in(link), .speed_100_in(spd), .full_duplex_in(dup), .tx_event_in(tx),
        .rx_event_in(rx), .col_event_in(col), .led_a_out(led_a_out), .led_b_out(led_b_out),
        .led_c_out(led_c_out));
    pledc_led_model pledc_led_model_i (.clk_in(clk_in), .clear_in(clear), .led_a_in(led_a_out),
        .led_b_in(led_b_out), .led_c_in(led_c_out), .lit_a_out(lit_a), .lit_b_out(lit_b),
        .lit_c_out(lit_c));
    // Free-running 40 MHz clock.
    always #12.5 clk_in = ~clk_in;
    // Prints the counts and the verdict, then stops the run.
    task automatic wrap_up();
        $display("Checks made: %0d, mismatches: %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // A hang counts as a mismatch; the ceiling is well above the planned length.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    // Single comparison point of the bench.
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        total_checks++;
        if (seen !== exp)
        begin
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
            n_mismatch++;
        end
    endtask : chk
    // Hold time in cycles of a hold code; the reserved code behaves as the shortest.
    function automatic int hold_len(input logic [1:0] h);
        return (h == 2'h1) ? int'(H60) : (h == 2'h2) ? int'(H100) : int'(H30);
    endfunction : hold_len
    // Level expected from a continuous or test code; unused codes leave the LED dark.
    function automatic logic cont_led(input logic [3:0] s, input logic l, p, d);
        return (s == 4'h0) ? p : (s == 4'h4) ? l : (s == 4'h5) ? d : (s == 4'h8);
    endfunction : cont_led
    // One write cycle; the strobe is a single-cycle pulse.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // One read cycle; data is registered at the taking edge and sampled mid-cycle.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        @(negedge clk_in);
        d = reg_rdata_out;
    endtask : rd
    // All three indicators get the same code so one run covers every select field.
    task automatic cfg(input logic [3:0] s, input logic [1:0] h, input logic st);
        wr(PLEDC_CFG_ADDR, {s, s, s, h, st, 1'b0});
    endtask : cfg
    // Event of len cycles on the code's source; lit time counted over 100 cycles.
    task automatic ev_run(input logic [3:0] s, input logic [1:0] h, input logic st, input int len);
        int dur;
        cfg(s, h, st);
        repeat (80) @(posedge clk_in);
        clear <= 1'b1;
        @(posedge clk_in);
        clear <= 1'b0;
        tx <= (s == 4'h1 || s == 4'hD);
        rx <= (s == 4'h2 || s == 4'h7 || s == 4'hC);
        col <= (s == 4'h3 || s == 4'hE);
        repeat (len) @(posedge clk_in);
        {tx, rx, col} <= 3'b000;
        repeat (100 - len) @(posedge clk_in);
        @(negedge clk_in);
        dur = (st || s >= 4'hC) ? hold_len(h) + len - 1 : len;
        dur = (s >= 4'hC) ? 100 - dur : dur;
        chk(lit_a, 16'(dur), "lit time a");
        chk((lit_b ^ lit_a) | (lit_c ^ lit_a), 16'h0000, "lit time b c");
    endtask : ev_run
    // Cycles between two changes of indicator a.
    task automatic half_period(output int cnt);
        logic prev;
        @(negedge clk_in);
        // The first change may be the switch of code, so the count starts at the second.
        repeat (2)
        begin
            prev = led_a_out;
            for (k = 0; k < 300 && led_a_out === prev; k++) @(negedge clk_in);
        end
        prev = led_a_out;
        cnt = 0;
        for (k = 0; k < 300 && led_a_out === prev; k++)
        begin
            @(negedge clk_in);
            cnt++;
        end
    endtask : half_period
    // Main sequence: reset, registers, continuous codes, events, blinking.
    initial
    begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        @(negedge clk_in);
        chk(leds_seen, 16'h0006, "leds after reset");
        rd(PLEDC_CFG_ADDR, rd_val);
        chk(rd_val, {4'h0, 4'h4, 4'h2, 2'h0, 1'b1, 1'b0}, "reset config");
        for (i = 0; i < 4; i++)
        begin
            n = $random(seed);
            wr(PLEDC_CFG_ADDR, n[15:0]);
            wr((n[20:16] == 5'h14) ? 5'h15 : n[20:16], ~n[15:0]);
            rd(PLEDC_CFG_ADDR, rd_val);
            chk(rd_val, n[15:0] & 16'hFFFE, "config readback");
            rd((n[20:16] == 5'h14) ? 5'h15 : n[20:16], rd_val);
            chk(rd_val, 16'h0000, "unmapped read");
        end
        foreach (cont_codes[j])
        begin
            cfg(cont_codes[j], 2'h0, 1'b1);
            for (i = 0; i < 8; i++)
            begin
                n = $random(seed);
                @(posedge clk_in);
                {link, spd, dup} <= n[2:0];
                @(posedge clk_in);
                @(negedge clk_in);
                exp3 = {3{cont_led(cont_codes[j], n[2], n[1], n[0])}};
                chk(leds_seen, 16'(exp3), "level view");
            end
        end
        @(posedge clk_in);
        {link, dup} <= 2'b11;
        foreach (ev_codes[j])
        begin
            ev_run(ev_codes[j], 2'h2, 1'b0, 1);
            for (i = 0; i < 2; i++)
            begin
                n = $random(seed);
                ev_run(ev_codes[j], n[1:0], n[2], 1 + (n[4:3] % 3));
            end
        end
        cfg(4'hA, 2'h0, 1'b1);
        half_period(n);
        chk(16'(n), 16'(FH), "fast half period");
        cfg(4'hB, 2'h0, 1'b1);
        half_period(n);
        chk(16'(n), 16'(SH), "slow half period");
        wrap_up();
    end
endmodule : pledc_top_tb_top
